//--- hdl/imc_consts.vh
/*
 * shared constants for the two-wire bus master: address header fields,
 * timing figures.
 * assumes a 20 MHz core clock; included by bare name.
 */
`ifndef IMC_CONSTS_VH
`define IMC_CONSTS_VH

// core clock rate in kHz
`define IMC_CORE_KHZ 20000
// default half period in core cycles for 100 kHz
`define IMC_HALF_DEF 12'd100
// width of the half-period setting
`define IMC_HALF_W 12
// 10-bit header top bits 11110
`define IMC_HDR_TOP 5'h1e
// direction bit values
`define IMC_DIR_WRITE 1'b0
`define IMC_DIR_READ 1'b1
// bits per byte on the wire
`define IMC_BITS 4'd8
// low limit of half-period count
`define IMC_HALF_MIN 12'd2

`endif

//--- hdl/imc_sync.v
/*
 * two-flop synchroniser for one level from outside the core clock domain.
 * assumes the input is a plain level; the output lags by two edges.
 */
`timescale 1ns/10ps
`default_nettype none

module imc_sync (
    input wire i_core_clk,
    input wire i_rst_n,
    input wire i_async,
    output reg o_sync
);

reg meta_reg;

// first flop is read only by the second
always @(posedge i_core_clk) begin
    if (!i_rst_n) begin
        meta_reg <= 1'b1;
        o_sync <= 1'b1;
    end else begin
        meta_reg <= i_async;
        o_sync <= meta_reg;
    end
end

endmodule // imc_sync

`default_nettype wire

//--- hdl/imc_master.v
/*
 * master side of a two-wire serial bus: start, address phases (7 and
 * 10 bit), byte transmit and receive with acknowledge, clock hold when
 * software lags, and stop.  status and control are plain ports.
 * assumes open-drain pads outside: an enable high pulls the wire low.
 * status reads and data accesses arrive as one-cycle strobes.
 */
`timescale 1ns/10ps
`default_nettype none
`include "imc_consts.vh"

module imc_master #(
    parameter HALF_W = `IMC_HALF_W
) (
    input wire i_core_clk,
    input wire i_rst_n,
    input wire i_unit_on,
    input wire [HALF_W-1:0] i_half_period,
    input wire i_start_req,
    input wire i_stop_req,
    input wire i_ack_enable,
    input wire i_event_irq_enable,
    input wire i_buffer_irq_enable,
    input wire i_data_wr,
    input wire [7:0] i_data_in,
    input wire i_data_rd,
    input wire i_status_one_rd,
    input wire i_status_two_rd,
    input wire i_scl_in,
    input wire i_sda_in,
    output wire o_scl_oe,
    output wire o_sda_oe,
    output reg [7:0] o_data_out,
    output reg o_master_active_flag,
    output reg o_start_sent_flag,
    output reg o_ten_bit_header_flag,
    output reg o_addr_sent_flag,
    output reg o_send_buffer_free,
    output reg o_receive_buffer_full,
    output reg o_byte_finished_flag,
    output reg o_arb_lost_flag,
    output reg o_ack_fail_flag,
    output wire o_event_irq
);

localparam ST_IDLE = 4'd0;
localparam ST_START = 4'd1;
localparam ST_WAIT_DATA = 4'd2;
localparam ST_BIT = 4'd3;
localparam ST_ACK = 4'd4;
localparam ST_HOLD = 4'd5;
localparam ST_STOP = 4'd6;
localparam ST_RSTART = 4'd7;

////////////////////////////////////////////////////////////////////////
// pin synchronisers
wire scl_s;
wire sda_s;

imc_sync u_sync_scl (
    .i_core_clk(i_core_clk),
    .i_rst_n(i_rst_n),
    .i_async(i_scl_in),
    .o_sync(scl_s)
);

imc_sync u_sync_sda (
    .i_core_clk(i_core_clk),
    .i_rst_n(i_rst_n),
    .i_async(i_sda_in),
    .o_sync(sda_s)
);

////////////////////////////////////////////////////////////////////////
// state
reg [3:0] state_reg;
reg [HALF_W-1:0] cnt_reg;
reg phase_reg;          // 0: clock low half, 1: clock high half
reg [3:0] bit_reg;
reg [7:0] shift_reg;
reg [7:0] tx_hold_reg;  // byte written by software
reg tx_loaded_reg;
reg scl_drive_reg;
reg sda_drive_reg;
reg rx_mode_reg;        // master receiver after address
reg [1:0] addr_left_reg; // address bytes still to send
reg ten_bit_reg;
reg ten_read_reg;       // 10-bit read header seen; receive follows low byte ack
reg [1:0] hdr_top_reg;
reg stat1_seen_reg;     // status-one read armed for a clear
reg nack_reg;

wire half_done = (cnt_reg == {HALF_W{1'b0}});
wire [HALF_W-1:0] half_load = (i_half_period < `IMC_HALF_MIN) ?
    `IMC_HALF_MIN : i_half_period;
// clock high phase waits while a slave stretches the wire
wire scl_stretched = phase_reg && !scl_s;

assign o_scl_oe = scl_drive_reg;
assign o_sda_oe = sda_drive_reg;

// event interrupt gating; buffer flags also need the buffer enable
assign o_event_irq = i_event_irq_enable & (o_start_sent_flag |
    o_ten_bit_header_flag | o_addr_sent_flag | o_byte_finished_flag |
    (i_buffer_irq_enable & (o_send_buffer_free |
    o_receive_buffer_full)));

////////////////////////////////////////////////////////////////////////
// software side: hold register and clear sequences
wire sw_clear_write = i_data_wr && stat1_seen_reg;
wire sw_clear_read = i_data_rd && stat1_seen_reg;

always @(posedge i_core_clk) begin
    if (!i_rst_n) begin
        stat1_seen_reg <= 1'b0;
        tx_hold_reg <= 8'h00;
        tx_loaded_reg <= 1'b0;
    end else begin
        if (i_status_one_rd) begin
            stat1_seen_reg <= 1'b1;
        end else if (i_data_wr || i_data_rd || i_status_two_rd) begin
            stat1_seen_reg <= 1'b0;
        end
        if (i_data_wr) begin
            tx_hold_reg <= i_data_in;
            tx_loaded_reg <= 1'b1;
        end else if (state_reg == ST_WAIT_DATA && tx_loaded_reg) begin
            tx_loaded_reg <= 1'b0;
        end else if (state_reg == ST_HOLD && tx_loaded_reg &&
                !o_byte_finished_flag && !o_addr_sent_flag &&
                !o_ten_bit_header_flag) begin
            tx_loaded_reg <= 1'b0;
        end
    end
end

////////////////////////////////////////////////////////////////////////
// main sequencer
always @(posedge i_core_clk) begin
    if (!i_rst_n) begin
        state_reg <= ST_IDLE;
        cnt_reg <= {HALF_W{1'b0}};
        phase_reg <= 1'b0;
        bit_reg <= 4'd0;
        shift_reg <= 8'h00;
        scl_drive_reg <= 1'b0;
        sda_drive_reg <= 1'b0;
        rx_mode_reg <= 1'b0;
        addr_left_reg <= 2'd0;
        ten_bit_reg <= 1'b0;
        ten_read_reg <= 1'b0;
        hdr_top_reg <= 2'd0;
        nack_reg <= 1'b0;
        o_data_out <= 8'h00;
        o_master_active_flag <= 1'b0;
        o_start_sent_flag <= 1'b0;
        o_ten_bit_header_flag <= 1'b0;
        o_addr_sent_flag <= 1'b0;
        o_send_buffer_free <= 1'b0;
        o_receive_buffer_full <= 1'b0;
        o_byte_finished_flag <= 1'b0;
        o_arb_lost_flag <= 1'b0;
        o_ack_fail_flag <= 1'b0;
    end else begin
        // software clears; hardware sets below override in same cycle
        if (sw_clear_write) begin
            o_start_sent_flag <= 1'b0;
            o_ten_bit_header_flag <= 1'b0;
        end
        if (i_data_wr) begin
            o_send_buffer_free <= 1'b0;
        end
        if (i_status_two_rd && stat1_seen_reg) begin
            o_addr_sent_flag <= 1'b0;
        end
        if (i_data_rd) begin
            o_receive_buffer_full <= 1'b0;
        end
        if (i_status_one_rd) begin
            o_arb_lost_flag <= 1'b0;
            o_ack_fail_flag <= 1'b0;
        end
        if (!half_done && !scl_stretched) begin
            cnt_reg <= cnt_reg - 1'b1;
        end
        case (state_reg)
        ST_IDLE: begin
            scl_drive_reg <= 1'b0;
            sda_drive_reg <= 1'b0;
            // only a free bus and an enabled unit may start
            if (i_unit_on && i_start_req && scl_s && sda_s) begin
                o_master_active_flag <= 1'b1;
                sda_drive_reg <= 1'b1;
                cnt_reg <= half_load;
                state_reg <= ST_START;
            end
        end
        ST_START: begin
            // data falls while clock high, then clock falls
            if (half_done) begin
                scl_drive_reg <= 1'b1;
                o_start_sent_flag <= 1'b1;
                addr_left_reg <= 2'd1;
                rx_mode_reg <= 1'b0;
                state_reg <= ST_WAIT_DATA;
            end
        end
        ST_WAIT_DATA: begin
            // clock held low until software supplies the address byte
            if (tx_loaded_reg) begin
                shift_reg <= tx_hold_reg;
                if (addr_left_reg == 2'd1 && !ten_read_reg) begin
                    // top five bits 11110 mark a 10-bit header
                    ten_bit_reg <= (tx_hold_reg[7:3] == `IMC_HDR_TOP);
                    hdr_top_reg <= tx_hold_reg[2:1];
                    ten_read_reg <= (tx_hold_reg[7:3] == `IMC_HDR_TOP) &&
                        tx_hold_reg[0];
                    if (tx_hold_reg[7:3] == `IMC_HDR_TOP) begin
                        addr_left_reg <= 2'd2;
                    end
                end
                bit_reg <= `IMC_BITS;
                phase_reg <= 1'b0;
                cnt_reg <= half_load;
                sda_drive_reg <= ~tx_hold_reg[7];
                state_reg <= ST_BIT;
            end
        end
        ST_BIT: begin
            if (half_done && !scl_stretched) begin
                cnt_reg <= half_load;
                if (!phase_reg) begin
                    phase_reg <= 1'b1;
                    scl_drive_reg <= 1'b0;
                end else begin
                    phase_reg <= 1'b0;
                    scl_drive_reg <= 1'b1;
                    if (rx_mode_reg) begin
                        shift_reg <= {shift_reg[6:0], sda_s};
                    end else if (sda_drive_reg == 1'b0 && !sda_s) begin
                        // another master pulled low: yield the bus
                        o_arb_lost_flag <= 1'b1;
                        o_master_active_flag <= 1'b0;
                        scl_drive_reg <= 1'b0;
                        state_reg <= ST_IDLE;
                    end
                    if (state_reg == ST_BIT && !(o_arb_lost_flag &&
                            1'b0)) begin
                        if (bit_reg == 4'd1) begin
                            state_reg <= ST_ACK;
                            // receiver acks unless final byte refused
                            sda_drive_reg <= rx_mode_reg &&
                                i_ack_enable;
                        end else begin
                            shift_reg <= rx_mode_reg ?
                                {shift_reg[6:0], sda_s} :
                                {shift_reg[6:0], 1'b0};
                            sda_drive_reg <= rx_mode_reg ? 1'b0 :
                                ~shift_reg[6];
                        end
                        bit_reg <= bit_reg - 4'd1;
                    end
                    if (!rx_mode_reg && sda_drive_reg == 1'b0 && !sda_s) begin
                        state_reg <= ST_IDLE;
                    end
                end
            end
        end
        ST_ACK: begin
            if (half_done && !scl_stretched) begin
                cnt_reg <= half_load;
                if (!phase_reg) begin
                    phase_reg <= 1'b1;
                    scl_drive_reg <= 1'b0;
                end else begin
                    phase_reg <= 1'b0;
                    scl_drive_reg <= 1'b1;
                    sda_drive_reg <= 1'b0;
                    nack_reg <= rx_mode_reg ? !i_ack_enable : sda_s;
                    state_reg <= ST_HOLD;
                    if (rx_mode_reg) begin
                        // old byte unread: keep it, new one waits in shift
                        if (o_receive_buffer_full && !i_data_rd) begin
                            o_byte_finished_flag <= 1'b1;
                        end else begin
                            o_data_out <= shift_reg;
                            o_receive_buffer_full <= 1'b1;
                        end
                    end else if (sda_s) begin
                        o_ack_fail_flag <= 1'b1;
                    end else if (addr_left_reg == 2'd2) begin
                        o_ten_bit_header_flag <= 1'b1;
                        addr_left_reg <= 2'd1;
                    end else if (addr_left_reg == 2'd1) begin
                        addr_left_reg <= 2'd0;
                        if (ten_read_reg && ten_bit_reg) begin
                            // low byte acked after a 10-bit read header: receive, no repeat start
                            rx_mode_reg <= 1'b1;
                            ten_read_reg <= 1'b0;
                            o_addr_sent_flag <= 1'b1;
                        end else if (ten_read_reg) begin
                            state_reg <= ST_RSTART;
                        end else begin
                            o_addr_sent_flag <= 1'b1;
                            // seven shifts left the direction bit on top
                            rx_mode_reg <= (!ten_bit_reg &&
                                shift_reg[7] == `IMC_DIR_READ);
                            o_send_buffer_free <= ten_bit_reg ||
                                shift_reg[7] == `IMC_DIR_WRITE;
                        end
                    end else if (!tx_loaded_reg && !i_data_wr) begin
                        // nothing written while this byte went out
                        o_byte_finished_flag <= o_send_buffer_free;
                        o_send_buffer_free <= 1'b1;
                    end
                end
            end
        end
        ST_HOLD: begin
            // clock held low; released by clear sequence or stop
            if (sw_clear_write || sw_clear_read) begin
                o_byte_finished_flag <= 1'b0;
                if (rx_mode_reg && o_byte_finished_flag && sw_clear_read) begin
                    // stalled byte moves up once the old one is read
                    o_data_out <= shift_reg;
                    o_receive_buffer_full <= 1'b1;
                end
            end
            if (i_stop_req || nack_reg) begin
                sda_drive_reg <= 1'b1;
                cnt_reg <= half_load;
                phase_reg <= 1'b0;
                state_reg <= ST_STOP;
            end else if (o_byte_finished_flag) begin
                state_reg <= ST_HOLD;
            end else if (rx_mode_reg && !o_addr_sent_flag) begin
                bit_reg <= `IMC_BITS;
                cnt_reg <= half_load;
                state_reg <= ST_BIT;
            end else if (!rx_mode_reg && tx_loaded_reg &&
                    !o_addr_sent_flag && !o_ten_bit_header_flag) begin
                shift_reg <= tx_hold_reg;
                // hold register empties into the shifter
                if (addr_left_reg == 2'd0) begin
                    o_send_buffer_free <= !i_data_wr;
                end
                sda_drive_reg <= ~tx_hold_reg[7];
                bit_reg <= `IMC_BITS;
                cnt_reg <= half_load;
                state_reg <= ST_BIT;
            end else if (addr_left_reg == 2'd1 && tx_loaded_reg &&
                    !o_ten_bit_header_flag) begin
                shift_reg <= tx_hold_reg;
                sda_drive_reg <= ~tx_hold_reg[7];
                bit_reg <= `IMC_BITS;
                cnt_reg <= half_load;
                state_reg <= ST_BIT;
            end
        end
        ST_RSTART: begin
            // release data, raise clock, then start again
            if (half_done && !scl_stretched) begin
                cnt_reg <= half_load;
                if (!phase_reg) begin
                    phase_reg <= 1'b1;
                    scl_drive_reg <= 1'b0;
                end else if (sda_drive_reg == 1'b0) begin
                    sda_drive_reg <= 1'b1;
                    ten_bit_reg <= 1'b1;
                    addr_left_reg <= 2'd1;
                    phase_reg <= 1'b0;
                    state_reg <= ST_START;
                end
            end
        end
        ST_STOP: begin
            // clock up with data low, then data up while clock high
            if (half_done && !scl_stretched) begin
                cnt_reg <= half_load;
                if (!phase_reg) begin
                    phase_reg <= 1'b1;
                    scl_drive_reg <= 1'b0;
                end else begin
                    sda_drive_reg <= 1'b0;
                    o_master_active_flag <= 1'b0;
                    // a cut transfer leaves no stall or empty flag behind
                    o_byte_finished_flag <= 1'b0;
                    o_send_buffer_free <= 1'b0;
                    ten_bit_reg <= 1'b0;
                    ten_read_reg <= 1'b0;
                    rx_mode_reg <= 1'b0;
                    state_reg <= ST_IDLE;
                end
            end
        end
        default: begin
            state_reg <= ST_IDLE;
        end
        endcase
        if (!i_unit_on) begin
            state_reg <= ST_IDLE;
            o_master_active_flag <= 1'b0;
            scl_drive_reg <= 1'b0;
            sda_drive_reg <= 1'b0;
        end
    end
end

endmodule // imc_master

`default_nettype wire

//--- tb/imc_properties.sv
/* port checker for the bus master.
   bound to every imc_master below; sees its ports only. */
`timescale 1ns/10ps
`default_nettype none
module imc_properties #(
    parameter HALF_W = 12
) (
    input wire i_core_clk,
    input wire i_rst_n,
    input wire i_unit_on,
    input wire i_start_req,
    input wire i_stop_req,
    input wire i_event_irq_enable,
    input wire i_buffer_irq_enable,
    input wire i_data_wr,
    input wire i_data_rd,
    input wire i_status_two_rd,
    input wire o_scl_oe,
    input wire o_sda_oe,
    input wire o_master_active_flag,
    input wire o_start_sent_flag,
    input wire o_ten_bit_header_flag,
    input wire o_addr_sent_flag,
    input wire o_send_buffer_free,
    input wire o_receive_buffer_full,
    input wire o_byte_finished_flag,
    input wire o_event_irq
);
////////////////////////////////////////////////////////////////////////////
default clocking cb @(posedge i_core_clk); endclocking
default disable iff (!i_rst_n);
// start seen, and the clock stall that follows a lagging cpu
sequence s_start_seen; $rose(o_start_sent_flag); endsequence
sequence s_stall; o_byte_finished_flag && o_master_active_flag; endsequence
property p_master_by_start;
    $rose(o_master_active_flag) |-> $past(i_start_req);
endproperty
property p_off_idle;
    !i_unit_on [*2] |-> !o_master_active_flag;
endproperty
property p_start_cond;
    s_start_seen |-> o_sda_oe && o_master_active_flag;
endproperty
property p_start_hold;
    o_start_sent_flag && !i_data_wr |=> o_start_sent_flag;
endproperty
property p_free_clear;
    i_data_wr && o_send_buffer_free |=> !o_send_buffer_free;
endproperty
property p_addr_hold;
    o_addr_sent_flag && !i_status_two_rd |=> o_addr_sent_flag;
endproperty
property p_full_hold;
    o_receive_buffer_full && !i_data_rd |=> o_receive_buffer_full;
endproperty
// stop may release a held clock, so it is excluded
property p_hold_low;
    s_stall and !i_stop_req |-> o_scl_oe;
endproperty
property p_evt_irq;
    i_event_irq_enable && (o_start_sent_flag || o_ten_bit_header_flag
        || o_addr_sent_flag) |-> o_event_irq;
endproperty
property p_buf_irq;
    i_event_irq_enable && i_buffer_irq_enable
        && (o_send_buffer_free || o_receive_buffer_full) |-> o_event_irq;
endproperty
property p_irq_off;
    !i_event_irq_enable |-> !o_event_irq;
endproperty
property p_release;
    $fell(o_master_active_flag) |-> !o_scl_oe;
endproperty
a_master_by_start: assert property (p_master_by_start) else $error("master without start");
a_off_idle: assert property (p_off_idle) else $error("master while off");
a_start_cond: assert property (p_start_cond) else $error("bad start");
a_start_hold: assert property (p_start_hold) else $error("start flag lost");
a_free_clear: assert property (p_free_clear) else $error("free not cleared");
a_addr_hold: assert property (p_addr_hold) else $error("addr flag lost");
a_full_hold: assert property (p_full_hold) else $error("full flag lost");
a_hold_low: assert property (p_hold_low) else $error("clock not held");
a_evt_irq: assert property (p_evt_irq) else $error("event irq missing");
a_buf_irq: assert property (p_buf_irq) else $error("buffer irq missing");
a_irq_off: assert property (p_irq_off) else $error("irq while masked");
a_release: assert property (p_release) else $error("clock kept on drop");
endmodule // imc_properties
bind imc_master imc_properties #(.HALF_W(HALF_W)) u_chk (.i_core_clk,
    .i_rst_n, .i_unit_on, .i_start_req, .i_stop_req, .i_event_irq_enable,
    .i_buffer_irq_enable, .i_data_wr, .i_data_rd, .i_status_two_rd,
    .o_scl_oe, .o_sda_oe, .o_master_active_flag, .o_start_sent_flag,
    .o_ten_bit_header_flag, .o_addr_sent_flag, .o_send_buffer_free,
    .o_receive_buffer_full, .o_byte_finished_flag, .o_event_irq);
`default_nettype wire

//--- tb/imc_slave_model.sv
/* slave on the two-wire bus: acks every address and written byte,
   sends queued bytes when read. assumes pull-ups on both wires. */
`timescale 1ns/10ps
`default_nettype none
module imc_slave_model (
    input wire logic i_scl,
    input wire logic i_sda,
    output var logic o_sda_oe
);
logic [7:0] sr, tx, rx_q[$], tx_q[$];
logic rd, first, ack_q[$];
int cnt = 99;
initial o_sda_oe = 1'b0;
////////////////////////////////////////////////////////////////////////////
// start and stop: data edges while the clock is high
// the master moves data in the step its clock falls: let the clock settle
always @(negedge i_sda) begin
    #1;
    if (i_scl) begin
        cnt = 0;
        first = 1'b1;
        rd = 1'b0;
    end
end
always @(posedge i_sda) begin
    #1;
    if (i_scl) cnt = 99;
end
// shift in msb first; in read, note the master's answer
always @(posedge i_scl) begin
    if (cnt < 8) sr = {sr[6:0], i_sda};
    else if (cnt == 8 && rd && !first) ack_q.push_back(!i_sda);
    cnt++;
end
// data only changes while the clock is low
always @(negedge i_scl) begin
    if (cnt == 8) begin
        o_sda_oe = !rd;
        if (!rd) rx_q.push_back(sr);
        if (first) rd = sr[0];
    end else if (cnt == 9) begin
        o_sda_oe = 1'b0;
        cnt = 0;
        if (rd && (first || ack_q[$])) begin
            tx = tx_q.pop_front();
            o_sda_oe = !tx[7];
        end else if (rd) cnt = 99; // no answer: wire left free
        first = 1'b0;
    end else if (rd && cnt < 8) o_sda_oe = !tx[7-cnt];
end
endmodule // imc_slave_model
`default_nettype wire

//--- tb/imc_master_bench.sv
/* bench for imc_master: open-drain wires with pull-ups, slave model,
   byte and flag checks. assumes model and checker compiled first. */
`timescale 1ns/10ps
`default_nettype none
`include "imc_consts.vh"
module imc_master_bench;
logic i_core_clk = 0, i_rst_n = 0, i_unit_on = 0, i_start_req = 0;
logic i_stop_req = 0, i_ack_enable = 0, i_event_irq_enable = 0;
logic i_buffer_irq_enable = 0, i_data_wr = 0, i_data_rd = 0;
logic i_status_one_rd = 0, i_status_two_rd = 0, s_oe;
logic [11:0] i_half_period = 12'h004; // short halves keep the run brief
logic [7:0] i_data_in = 8'h00, o_data_out, a, b, c, m_q[$];
logic o_scl_oe, o_sda_oe, o_master_active_flag, o_start_sent_flag;
logic o_ten_bit_header_flag, o_addr_sent_flag, o_send_buffer_free;
logic o_receive_buffer_full, o_byte_finished_flag, o_arb_lost_flag;
logic o_ack_fail_flag, o_event_irq;
int error_cnt = 0, checks = 0, seed = 58526;
// slave never stretches, so only the master pulls the clock
wire scl = ~o_scl_oe;
wire sda = ~(o_sda_oe | s_oe);
imc_master dut (.i_core_clk, .i_rst_n, .i_unit_on, .i_half_period,
    .i_start_req, .i_stop_req, .i_ack_enable, .i_event_irq_enable,
    .i_buffer_irq_enable, .i_data_wr, .i_data_in, .i_data_rd,
    .i_status_one_rd, .i_status_two_rd, .i_scl_in(scl), .i_sda_in(sda),
    .o_scl_oe, .o_sda_oe, .o_data_out, .o_master_active_flag,
    .o_start_sent_flag, .o_ten_bit_header_flag, .o_addr_sent_flag,
    .o_send_buffer_free, .o_receive_buffer_full, .o_byte_finished_flag,
    .o_arb_lost_flag, .o_ack_fail_flag, .o_event_irq);
imc_slave_model slv (.i_scl(scl), .i_sda(sda), .o_sda_oe(s_oe));
always #25 i_core_clk = ~i_core_clk;
////////////////////////////////////////////////////////////////////////////
// compare, report, close
task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    checks++;
    if (g !== e) begin
        error_cnt++;
        $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
endtask
task automatic results();
    $display("checks %0d mismatches %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
endtask
function automatic logic [7:0] rnd();
    logic [31:0] r;
    r = $random(seed);
    return r[7:0];
endfunction
// 8 master, 7 start, 6 header, 5 addr, 4 free, 3 full, 2 finished
function automatic logic fl(input int i);
    logic [8:0] f;
    f = {o_master_active_flag, o_start_sent_flag, o_ten_bit_header_flag,
        o_addr_sent_flag, o_send_buffer_free, o_receive_buffer_full,
        o_byte_finished_flag, o_scl_oe, 1'b0};
    return f[i];
endfunction
// bounded wait; settled values read 1 ns after the edge
task automatic wt(input int i, input logic v);
    int k;
    k = 0;
    do begin
        @(posedge i_core_clk);
        #1 k++;
    end while (fl(i) !== v && k < 3000);
    chk("flag wait", {7'h0, v}, {7'h0, fl(i)});
endtask
// 0 status one, 1 status two, 2 data read
task automatic pls(input int i);
    @(posedge i_core_clk);
    case (i)
        0: i_status_one_rd <= 1'b1;
        1: i_status_two_rd <= 1'b1;
        default: i_data_rd <= 1'b1;
    endcase
    @(posedge i_core_clk);
    {i_status_one_rd, i_status_two_rd, i_data_rd} <= 3'h0;
endtask
task automatic wrb(input logic [7:0] v);
    m_q.push_back(v);
    @(posedge i_core_clk);
    i_data_in <= v;
    i_data_wr <= 1'b1;
    @(posedge i_core_clk);
    i_data_wr <= 1'b0;
endtask
task automatic open_bus(input logic [7:0] v);
    @(posedge i_core_clk);
    i_start_req <= 1'b1;
    wt(7, 1'b1);
    chk("master", 8'h01, {7'h0, fl(8)});
    @(posedge i_core_clk);
    i_start_req <= 1'b0;
    pls(0);
    #1 chk("start kept", 8'h01, {7'h0, fl(7)});
    wrb(v);
    #1 chk("start clr", 8'h00, {7'h0, fl(7)});
endtask
task automatic close_bus(input string n);
    @(posedge i_core_clk);
    i_stop_req <= 1'b1;
    wt(8, 1'b0);
    @(posedge i_core_clk);
    i_stop_req <= 1'b0;
    chk("arb lost", 8'h00, {7'h0, o_arb_lost_flag});
    chk("bytes", m_q.size(), slv.rx_q.size());
    foreach (m_q[k]) chk("wire byte", m_q[k], slv.rx_q[k]);
    m_q.delete();
    slv.rx_q.delete();
    $display("test %s done, mismatches %0d", n, error_cnt);
endtask
task automatic addr_done();
    wt(5, 1'b1);
    pls(0);
    pls(1);
    #1 chk("addr clr", 8'h00, {7'h0, fl(5)});
endtask
////////////////////////////////////////////////////////////////////////////
initial begin
    repeat (30000) @(posedge i_core_clk);
    error_cnt++;
    results();
end
initial begin
    repeat (16) @(posedge i_core_clk);
    i_rst_n <= 1'b1;
    i_start_req <= 1'b1;
    repeat (40) @(posedge i_core_clk);
    #1 chk("off master", 8'h00, {7'h0, fl(8)});
    @(posedge i_core_clk);
    i_start_req <= 1'b0;
    i_unit_on <= 1'b1;
    i_event_irq_enable <= 1'b1;
    i_buffer_irq_enable <= 1'b1;
    // 7-bit write, then a stall that holds the clock low
    a = rnd();
    open_bus({1'b0, a[5:0], `IMC_DIR_WRITE});
    addr_done();
    repeat (2) begin
        wt(4, 1'b1);
        wrb(rnd());
    end
    wt(2, 1'b1);
    repeat (30) @(posedge i_core_clk);
    #1 chk("held low", 8'h01, {7'h0, fl(1)});
    chk("irq", 8'h01, {7'h0, o_event_irq});
    chk("ack fail", 8'h00, {7'h0, o_ack_fail_flag});
    close_bus("write7");
    // 10-bit write: header, low byte, one data byte
    i_buffer_irq_enable <= 1'b0;
    b = rnd();
    open_bus({`IMC_HDR_TOP, b[1:0], 1'b0});
    wt(6, 1'b1);
    pls(0);
    wrb(rnd());
    #1 chk("hdr clr", 8'h00, {7'h0, fl(6)});
    addr_done();
    wt(4, 1'b1);
    wrb(rnd());
    wt(2, 1'b1);
    close_bus("write10");
    // 7-bit read of two bytes, last one refused
    i_buffer_irq_enable <= 1'b1;
    i_ack_enable <= 1'b1;
    b = rnd();
    c = rnd();
    slv.tx_q.push_back(b);
    slv.tx_q.push_back(c);
    open_bus({1'b0, a[5:0], `IMC_DIR_READ});
    addr_done();
    wt(3, 1'b1);
    chk("first rx", b, o_data_out);
    @(posedge i_core_clk);
    i_ack_enable <= 1'b0;
    pls(0);
    pls(2);
    wt(3, 1'b1);
    chk("last rx", c, o_data_out);
    chk("acks", 8'h02, {6'h0, slv.ack_q[0], slv.ack_q[1]});
    pls(0);
    pls(2);
    close_bus("read7");
    results();
end
endmodule // imc_master_bench
`default_nettype wire
